// ### core/asp_uart.sv
// Purpose: Full-duplex async serial port with 8/9-bit frames and address filter
// Assumes: All inputs synchronous to sys_clk; ext_osc_tick is a one-cycle pulse
// Notes: Interrupt line is combinational-free, registered from flags
//
// Summary of operation
// - Control bit 7 selects frame mode.
// - One data address: read gives received byte, write loads transmitter.
// - Receive byte held in buffer while next frame shifts in.
// - Interrupt raised when enabled and either completion flag is set.
// - Only software clears the completion flags.
// - Transmit and receive bit clocks are timer overflows divided by two.
// - Hidden receive timer runs with the baud timer, same reload.
// - Start bit detection reloads the hidden receive timer.
// - Baud equals timer clock over 256 minus reload, halved.
// - Timer clock: system clock, divided by 4, 12, 48, or external by 8.
// - 8-bit frame: start, eight data bits LSB first, stop.
// - 8-bit mode stores stop bit as ninth receive bit.
// - Data write starts transmit; complete flag set at stop bit start.
// - Reception needs the receive enable bit set.
// - 8-bit load only if flag clear and, with address filter, stop one.
// - Failed load leaves buffer, ninth bit and flag untouched.
// - Overrun keeps the first byte; later data is lost.
// - 9-bit frame adds transmit ninth bit before stop.
// - 9-bit mode stores ninth bit; filter loads only when it is one.
`timescale 1ns/1ps
module asp_uart
   import asp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire asp_pkg::asp_req_t req,
   output logic [7:0] rdata,
   input wire logic ext_osc_tick,
   input wire logic int_enable,
   input wire logic rx_pin,
   output logic tx_pin,
   output logic irq
);
   import asp_pkg::*;

   // ======================================================
   // Registers
   logic [7:0] ctrl;
   logic [7:0] rx_buf;
   logic [7:0] reload;
   logic [7:0] baudcfg;
   logic [7:0] tx_timer;
   logic [7:0] rx_timer;
   logic [5:0] pre_cnt;
   logic [2:0] ext_cnt;

   wire wr_ctrl = req.wr && req.addr == ASP_ADDR_CTRL;
   wire wr_data = req.wr && req.addr == ASP_ADDR_DATA;
   wire wr_timer = req.wr && req.addr == ASP_ADDR_TIMER;
   wire wr_reload = req.wr && req.addr == ASP_ADDR_RELOAD;
   wire wr_cfg = req.wr && req.addr == ASP_ADDR_BAUDCFG;
   wire mode9 = ctrl[ASP_CTL_MODE];
   wire timer_run = baudcfg[ASP_CFG_RUN];

   // ======================================================
   // Timer clock select
   function automatic logic div_hit(input logic [5:0] cnt, input int div);
      div_hit = cnt % 6'(div) == 6'h00;
   endfunction

   logic tclk;
   always_comb begin
      case (asp_clksel_t'(baudcfg[2:0]))
         ASP_CLK_SYS: tclk = 1'b1;
         ASP_CLK_DIV4: tclk = div_hit(pre_cnt, ASP_DIV4);
         ASP_CLK_DIV12: tclk = div_hit(pre_cnt, ASP_DIV12);
         ASP_CLK_DIV48: tclk = div_hit(pre_cnt, ASP_DIV48);
         ASP_CLK_EXT8: tclk = ext_osc_tick && ext_cnt == 3'(ASP_EXT_DIV - 1);
         default: tclk = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         pre_cnt <= 6'h00;
         ext_cnt <= 3'h0;
      end else begin
         pre_cnt <= (pre_cnt == 6'(ASP_DIV48 - 1)) ? 6'h00 : pre_cnt + 6'h01;
         if (ext_osc_tick) begin
            ext_cnt <= ext_cnt + 3'h1;
         end
      end
   end

   // ======================================================
   // Baud timers: overflow reloads from reload byte
   wire tx_ovf = timer_run && tclk && tx_timer == 8'hff;
   wire rx_ovf = timer_run && tclk && rx_timer == 8'hff;
   logic rx_reload_req;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         tx_timer <= 8'h00;
         rx_timer <= 8'h00;
      end else begin
         if (wr_timer) begin
            tx_timer <= req.wdata;
         end else if (timer_run && tclk) begin
            tx_timer <= tx_ovf ? reload : tx_timer + 8'h01;
         end
         if (rx_reload_req) begin
            rx_timer <= reload;
         end else if (timer_run && tclk) begin
            rx_timer <= rx_ovf ? reload : rx_timer + 8'h01;
         end
      end
   end

   // Divide-by-two of overflow streams
   logic tx_half;
   logic rx_half;
   wire tx_tick = tx_ovf && tx_half;
   wire rx_tick = rx_ovf && rx_half;

   // ======================================================
   // Transmitter
   logic [10:0] tx_shift;
   logic [3:0] tx_left;
   logic tx_busy;
   logic ti_set;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         tx_shift <= 11'h7ff;
         tx_left <= 4'h0;
         tx_busy <= 1'b0;
         tx_pin <= 1'b1;
         tx_half <= 1'b0;
         ti_set <= 1'b0;
      end else begin
         ti_set <= 1'b0;
         if (tx_ovf) begin
            tx_half <= ~tx_half;
         end
         if (wr_data && !tx_busy) begin
            // Start, data LSB first, optional ninth bit, stop
            tx_shift <= mode9 ? {1'b1, ctrl[ASP_CTL_TB8], req.wdata, 1'b0}
                              : {2'b11, req.wdata, 1'b0};
            tx_left <= mode9 ? 4'(ASP_TX_BITS_9) : 4'(ASP_TX_BITS_8);
            tx_busy <= 1'b1;
         end else if (tx_busy && tx_tick && tx_left == 4'h0) begin
            // Stop bit has stood a full bit time; a new write may start now
            tx_busy <= 1'b0;
         end else if (tx_busy && tx_tick) begin
            tx_pin <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_left <= tx_left - 4'h1;
            if (tx_left == 4'h1) begin
               ti_set <= 1'b1;
            end
         end
      end
   end

   // ======================================================
   // Receiver: samples once per bit at the half-bit overflow
   asp_rx_state_t rx_state;
   logic [8:0] rx_shift;
   logic [3:0] rx_cnt;
   logic ri_set;
   logic rx_prev;
   wire [3:0] rx_data_bits = mode9 ? 4'h9 : 4'h8;
   wire ninth_ok = mode9 ? rx_shift[8] : rx_pin;
   // Overrun: a full buffer blocks the load, so the first byte survives
   wire load_ok = !ctrl[ASP_CTL_RI] && (!ctrl[ASP_CTL_MCE] || ninth_ok);

   assign rx_reload_req = rx_state == ASP_RX_IDLE && ctrl[ASP_CTL_REN]
                          && rx_prev && !rx_pin;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rx_state <= ASP_RX_IDLE;
         rx_shift <= 9'h000;
         rx_cnt <= 4'h0;
         rx_half <= 1'b0;
         rx_prev <= 1'b1;
         ri_set <= 1'b0;
         rx_buf <= 8'h00;
      end else begin
         rx_prev <= rx_pin;
         ri_set <= 1'b0;
         if (rx_reload_req) begin
            rx_half <= 1'b0;
         end else if (rx_ovf) begin
            rx_half <= ~rx_half;
         end
         case (rx_state)
            ASP_RX_IDLE: begin
               if (rx_reload_req) begin
                  rx_state <= ASP_RX_START;
               end
            end
            ASP_RX_START: begin
               // First overflow after reload lands mid start bit
               if (rx_ovf && !rx_half) begin
                  rx_state <= rx_pin ? ASP_RX_IDLE : ASP_RX_DATA;
                  rx_cnt <= 4'h0;
               end
            end
            ASP_RX_DATA: begin
               if (rx_ovf && !rx_half) begin
                  rx_shift <= {rx_pin, rx_shift[8:1]};
                  rx_cnt <= rx_cnt + 4'h1;
                  if (rx_cnt == rx_data_bits - 4'h1) begin
                     rx_state <= ASP_RX_STOP;
                  end
               end
            end
            ASP_RX_STOP: begin
               if (rx_ovf && !rx_half) begin
                  rx_state <= ASP_RX_IDLE;
                  if (load_ok) begin
                     rx_buf <= mode9 ? rx_shift[7:0] : rx_shift[8:1];
                     ri_set <= 1'b1;
                  end
               end
            end
            default: rx_state <= ASP_RX_IDLE;
         endcase
      end
   end

   // Ninth receive bit: stop bit in 8-bit mode, ninth data bit in 9-bit mode
   wire rb8_val = mode9 ? rx_shift[8] : rx_pin;

   // ======================================================
   // Read selection
   logic [7:0] rd_sel;
   always_comb begin
      case (req.addr)
         ASP_ADDR_CTRL: rd_sel = ctrl;
         ASP_ADDR_DATA: rd_sel = rx_buf;
         ASP_ADDR_TIMER: rd_sel = tx_timer;
         ASP_ADDR_RELOAD: rd_sel = reload;
         ASP_ADDR_BAUDCFG: rd_sel = baudcfg;
         default: rd_sel = 8'h00;
      endcase
   end

   // ======================================================
   // Control register: hardware set beats software clear
   logic [7:0] next_ctrl;
   always_comb begin
      next_ctrl = wr_ctrl ? {req.wdata[7], 1'b1, req.wdata[5:0]} : ctrl;
      if (rx_state == ASP_RX_STOP && rx_ovf && !rx_half && load_ok) begin
         next_ctrl[ASP_CTL_RB8] = rb8_val;
      end
      if (ti_set) begin
         next_ctrl[ASP_CTL_TI] = 1'b1;
      end
      if (ri_set) begin
         next_ctrl[ASP_CTL_RI] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl <= ASP_CTRL_RESET;
         reload <= ASP_RELOAD_RESET;
         baudcfg <= ASP_BAUDCFG_RESET;
         rdata <= 8'h00;
         irq <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         if (wr_reload) begin
            reload <= req.wdata;
         end
         if (wr_cfg) begin
            baudcfg <= {4'h0, req.wdata[3:0]};
         end
         irq <= int_enable && (next_ctrl[ASP_CTL_TI] || next_ctrl[ASP_CTL_RI]);
         // Zero outside the read slot keeps the bus quiet for an OR tree
         rdata <= req.rd ? rd_sel : 8'h00;
      end
   end
endmodule

// ### core/asp_pkg.sv
// Purpose: Shared constants and types for the async serial port
// Assumes: Register port with 8-bit data, one-cycle read latency
// Notes: Control reset value keeps bit 6 set, as the unused bit reads one
package asp_pkg;
   // ======================================================
   // Register map
   localparam logic [2:0] ASP_ADDR_CTRL = 3'h0;
   localparam logic [2:0] ASP_ADDR_DATA = 3'h1;
   localparam logic [2:0] ASP_ADDR_TIMER = 3'h2;
   localparam logic [2:0] ASP_ADDR_RELOAD = 3'h3;
   localparam logic [2:0] ASP_ADDR_BAUDCFG = 3'h4;
   // ======================================================
   // Control field positions
   localparam int ASP_CTL_MODE = 7;
   localparam int ASP_CTL_UNUSED = 6;
   localparam int ASP_CTL_MCE = 5;
   localparam int ASP_CTL_REN = 4;
   localparam int ASP_CTL_TB8 = 3;
   localparam int ASP_CTL_RB8 = 2;
   localparam int ASP_CTL_TI = 1;
   localparam int ASP_CTL_RI = 0;
   localparam logic [7:0] ASP_CTRL_RESET = 8'h40;
   // Baud config: bit 3 timer run, bits 2:0 clock source
   localparam int ASP_CFG_RUN = 3;
   localparam logic [7:0] ASP_BAUDCFG_RESET = 8'h00;
   localparam logic [7:0] ASP_RELOAD_RESET = 8'h00;
   // Timer prescale counts
   localparam int ASP_DIV4 = 4;
   localparam int ASP_DIV12 = 12;
   localparam int ASP_DIV48 = 48;
   localparam int ASP_EXT_DIV = 8;
   localparam logic [8:0] ASP_TIMER_SPAN = 9'h100;
   // Transmit bits per frame: start, data, optional ninth bit, stop
   localparam int ASP_TX_BITS_8 = 10;
   localparam int ASP_TX_BITS_9 = 11;

   typedef enum logic [2:0] {
      ASP_CLK_SYS = 3'b000,
      ASP_CLK_DIV4 = 3'b001,
      ASP_CLK_DIV12 = 3'b010,
      ASP_CLK_DIV48 = 3'b011,
      ASP_CLK_EXT8 = 3'b100
   } asp_clksel_t;

   typedef enum logic [1:0] {
      ASP_RX_IDLE = 2'b00,
      ASP_RX_START = 2'b01,
      ASP_RX_DATA = 2'b10,
      ASP_RX_STOP = 2'b11
   } asp_rx_state_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } asp_req_t;
endpackage

// ### testbench/asp_checker.sv
// Purpose: Port-level checks for the async serial port
// Assumes: Sees only the asp_uart ports
// Notes: Flags are seen through irq and control reads
`timescale 1ns/1ps
module asp_checker
   import asp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire asp_pkg::asp_req_t req,
   input wire logic [7:0] rdata,
   input wire logic ext_osc_tick,
   input wire logic int_enable,
   input wire logic rx_pin,
   input wire logic tx_pin,
   input wire logic irq
);
   logic tx_armed;
   wire ctl_wr = req.wr && req.addr == ASP_ADDR_CTRL;
   wire ctl_rd = req.rd && req.addr == ASP_ADDR_CTRL;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // ======================================================
   // Helper: no frame may leave before a data write
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         tx_armed <= 1'b0;
      end else if (req.wr && req.addr == ASP_ADDR_DATA) begin
         tx_armed <= 1'b1;
      end
   end
   // ======================================================
   // Assertions
   a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> tx_pin && !irq && rdata == 8'h0)
      else $error("outputs not quiet during reset");
   a_rdata_pulse: assert property (!req.rd |=> rdata == 8'h0)
      else $error("read data outside read slot");
   a_unmapped_zero: assert property (req.rd && req.addr > ASP_ADDR_BAUDCFG |=> rdata == 8'h0)
      else $error("unmapped read not zero");
   a_ctrl_spare: assert property (ctl_rd |=> rdata[ASP_CTL_UNUSED])
      else $error("control spare bit not one");
   a_irq_gated: assert property (!int_enable |=> !irq)
      else $error("irq while disabled");
   a_irq_cause: assert property (irq && ctl_rd |=> rdata[ASP_CTL_TI] || rdata[ASP_CTL_RI])
      else $error("irq without a flag");
   a_flag_sticky: assert property (irq && int_enable && !ctl_wr |=> irq)
      else $error("flag dropped without software");
   a_no_early_tx: assert property (!tx_armed |-> tx_pin)
      else $error("line left idle without a write");
   a_start_held: assert property ($fell(tx_pin) |=> !tx_pin)
      else $error("start bit too short");
   c_rx_irq: cover property (irq && req.rd && req.addr == ASP_ADDR_DATA);
   c_tx_start: cover property ($fell(tx_pin));
   c_unmapped: cover property (req.rd && req.addr > ASP_ADDR_BAUDCFG);
endmodule

// ### testbench/asp_peer.sv
// Purpose: Remote serial node on the port's serial pins
// Assumes: Bench sets bit_cyc in sys_clk cycles and nbits
// Notes: Line idles at mark level between frames
`timescale 1ns/1ps
module asp_peer (
   input wire logic sys_clk,
   input wire logic line_in,
   output logic line_out
);
   int bit_cyc = 8;
   int nbits = 8;
   int got_cnt = 0;
   logic [9:0] got;
   // ======================================================
   // Sender: start, data LSB first, ninth when asked, stop
   task automatic send(input logic [8:0] d, input int n, input logic stop);
      for (int i = 0; i < n + 2; i++) begin
         @(posedge sys_clk);
         line_out <= (i == 0) ? 1'b0 : (i > n) ? stop : d[i - 1];
         repeat (bit_cyc - 1) @(posedge sys_clk);
      end
      @(posedge sys_clk);
      line_out <= 1'b1;
   endtask
   // ======================================================
   // Receiver: mid-bit sampling, stop kept above the data
   initial begin
      line_out = 1'b1;
      forever begin
         @(negedge line_in);
         repeat (bit_cyc / 2) @(posedge sys_clk);
         for (int i = 0; i <= nbits; i++) begin
            repeat (bit_cyc) @(posedge sys_clk);
            got[i] = line_in;
         end
         got_cnt++;
      end
   end
endmodule

// ### testbench/tb.sv
// Purpose: Self-checking bench for the async serial port
// Assumes: Peer model on the serial pins, register port driven here
// Notes: Seed fixed at 81 so runs repeat
`timescale 1ns/1ps
`define CHK(name, exp, got) \
   begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
   $display("unexpected %s: expected %h, seen %h", name, exp, got); end end
bind asp_uart asp_checker u_asp_checker (.sys_clk(sys_clk), .nrst(nrst), .req(req),
   .rdata(rdata), .ext_osc_tick(ext_osc_tick), .int_enable(int_enable), .rx_pin(rx_pin),
   .tx_pin(tx_pin), .irq(irq));
module tb;
   import asp_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic ext_osc_tick = 1'b0;
   logic int_enable = 1'b0;
   asp_req_t req = '0;
   logic [7:0] rdata;
   logic tx_pin;
   logic rx_pin;
   logic irq;
   int bad_count = 0;
   int comparisons = 0;
   int seed = 81;
   int n0;
   int divs [5] = '{1, 4, 12, 48, 16};
   logic [7:0] d;
   logic [7:0] buf_exp = 8'h00;
   logic rb8_exp = 1'b0;
   logic [7:0] rx_ctl [6] = '{8'h30, 8'hb0, 8'hb0, 8'h00, 8'h10, 8'h90};
   logic [5:0] rx_bit9 = 6'b011100;
   logic [5:0] rx_load = 6'b110100;
   asp_uart u_asp_uart (.sys_clk(sys_clk), .nrst(nrst), .req(req), .rdata(rdata),
      .ext_osc_tick(ext_osc_tick), .int_enable(int_enable), .rx_pin(rx_pin),
      .tx_pin(tx_pin), .irq(irq));
   asp_peer u_asp_peer (.sys_clk(sys_clk), .line_in(tx_pin), .line_out(rx_pin));
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) ext_osc_tick <= ~ext_osc_tick;
   // ======================================================
   // Register port and expectations
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1;
      `CHK(n, e, rdata)
   endtask
   function automatic logic [7:0] exp_ctl(input logic [7:0] sw, input logic rb8, input logic ri);
      return {sw[7], 1'b1, sw[5:3], rb8, 1'b0, ri};
   endfunction
   task automatic finish_test();
      $display("comparisons %0d, bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wait_peer();
      int k = 0;
      while (u_asp_peer.got_cnt == n0 && k < 4000) begin
         @(posedge sys_clk);
         k++;
      end
      if (k == 4000) begin
         bad_count++;
         finish_test();
      end
   endtask
   // ======================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(ASP_ADDR_CTRL, ASP_CTRL_RESET, "control reset");
      rd(ASP_ADDR_BAUDCFG, 8'h00, "baudcfg reset");
      rd(3'h5, 8'h00, "unmapped");
      wr(ASP_ADDR_RELOAD, 8'hfe);
      rd(ASP_ADDR_RELOAD, 8'hfe, "reload");
      wr(ASP_ADDR_TIMER, 8'h5a);
      rd(ASP_ADDR_TIMER, 8'h5a, "timer");
      // Every timer source, bit time 2 * 2 * divider
      for (int s = 0; s < 5; s++) begin
         u_asp_peer.bit_cyc = 4 * divs[s];
         wr(ASP_ADDR_BAUDCFG, {5'h01, 3'(s)});
         d = 8'($random(seed));
         n0 = u_asp_peer.got_cnt;
         wr(ASP_ADDR_DATA, d);
         wait_peer();
         `CHK("tx frame", {1'b1, d}, u_asp_peer.got[8:0])
         repeat (u_asp_peer.bit_cyc) @(posedge sys_clk);
      end
      wr(ASP_ADDR_RELOAD, 8'hfc);
      wr(ASP_ADDR_BAUDCFG, 8'h08);
      u_asp_peer.bit_cyc = 8;
      u_asp_peer.nbits = 9;
      int_enable <= 1'b1;
      // Address then data byte in 9-bit frames
      for (int m = 1; m >= 0; m--) begin
         wr(ASP_ADDR_CTRL, m ? 8'h98 : 8'h90);
         d = 8'($random(seed));
         n0 = u_asp_peer.got_cnt;
         wr(ASP_ADDR_DATA, d);
         wait_peer();
         `CHK("tx 9-bit frame", {1'b1, m[0], d}, u_asp_peer.got)
         rd(ASP_ADDR_CTRL, exp_ctl(m ? 8'h98 : 8'h90, 1'b0, 1'b0) | 8'h02, "tx flag");
         `CHK("tx irq", 1'b1, irq)
         repeat (8) @(posedge sys_clk);
      end
      // Receive cases: filter, stop, ninth bit, enable
      for (int c = 0; c < 6; c++) begin
         wr(ASP_ADDR_CTRL, rx_ctl[c]);
         d = (c == 0) ? 8'h00 : 8'($random(seed));
         u_asp_peer.send({rx_bit9[c], d}, rx_ctl[c][7] ? 9 : 8, rx_ctl[c][7] | rx_bit9[c]);
         repeat (4) @(posedge sys_clk);
         // Each control write clears the ninth bit field; only a load sets it again
         rb8_exp = rx_load[c] & rx_bit9[c];
         if (rx_load[c]) begin
            buf_exp = d;
         end
         rd(ASP_ADDR_CTRL, exp_ctl(rx_ctl[c], rb8_exp, rx_load[c]), "rx flags");
         rd(ASP_ADDR_DATA, buf_exp, "rx data");
         `CHK("rx irq", rx_load[c], irq)
      end
      // Overrun: flag still set, second byte must be lost
      u_asp_peer.send({1'b1, 8'($random(seed))}, 9, 1'b1);
      repeat (4) @(posedge sys_clk);
      rd(ASP_ADDR_DATA, buf_exp, "overrun data");
      finish_test();
   end
endmodule
